// ### els_pkg.sv
/*
 * Package of the exterior lamp sequencer: timing constants, key codes,
 * register map and the packed carriers of inputs and outputs.
 * Assumes a 250 MHz core clock and a millisecond tick made from it.
 */
package els_pkg;

   // Clock and millisecond tick
   localparam int CLK_PERIOD_NS  = 4;
   localparam int TICK_PERIOD_NS = 1_000_000;
   localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam int TICK_W         = 18;

   // Times in their own units, then as millisecond counts
   localparam int MS_W           = 19;
   localparam int FH_STEP_S      = 30;
   localparam int FH_MAX_EXT     = 8;
   localparam int KEYOFF_WIN_MIN = 2;
   localparam int FLASH_LONG_S   = 2;
   localparam int APPROACH_S     = 60;
   localparam int HAZ_MIN_S      = 3;
   localparam int HAZ_HALF_MS    = 200;
   localparam int SPEED_SAMPLE_MS = 10;
   localparam logic [MS_W-1:0] FH_STEP_MS    = MS_W'(FH_STEP_S * 1000);
   localparam logic [MS_W-1:0] KEYOFF_WIN_MS =
      MS_W'(KEYOFF_WIN_MIN * 60 * 1000);
   localparam logic [MS_W-1:0] APPROACH_MS   = MS_W'(APPROACH_S * 1000);
   localparam logic [11:0]     FLASH_LONG_MS = 12'(FLASH_LONG_S * 1000);
   localparam logic [11:0]     HAZ_MIN_MS    = 12'(HAZ_MIN_S * 1000);
   localparam logic [7:0]      HAZ_HALF_CNT  = 8'(HAZ_HALF_MS);
   localparam logic [3:0]      SAMPLE_CNT    = 4'(SPEED_SAMPLE_MS);
   localparam logic [3:0]      EXT_MAX       = 4'(FH_MAX_EXT);

   // Deceleration test on two five-sample speed sums (km/h)
   localparam int SAMPLES_PER_AVG = 5;
   localparam int SPEED_MIN_KMH   = 50;
   localparam int DECEL_MPS2      = 6;
   localparam logic [2:0]  SAMPLE_LAST = 3'(SAMPLES_PER_AVG - 1);
   localparam logic [10:0] SPEED_SUM_MIN =
      11'(SPEED_MIN_KMH * SAMPLES_PER_AVG);
   // Ten times the sum difference that equals the deceleration limit
   localparam logic [14:0] DECEL_SUM_X10 = 15'(DECEL_MPS2 *
      SAMPLES_PER_AVG * SAMPLES_PER_AVG * SPEED_SAMPLE_MS * 36 / 1000);

   // Key switch position codes
   localparam logic [1:0] KEY_OFF = 2'h0;
   localparam logic [1:0] KEY_ACC = 2'h1;
   localparam logic [1:0] KEY_ON  = 2'h2;

   // Register map, byte addresses
   localparam logic [31:0] REG_CTRL     = 32'h0000_0000;
   localparam logic [31:0] REG_STATUS   = 32'h0000_0004;
   localparam logic [31:0] REG_DURATION = 32'h0000_0008;
   localparam int          CTRL_FH_EN   = 0;
   localparam int          CTRL_DRL_EN  = 1;
   localparam logic [1:0]  CTRL_RESET   = 2'h3;

   // Synchronised switch and network inputs
   typedef struct packed {
      logic [1:0] key_switch_position;
      logic       flash_sw;
      logic       high_sw;
      logic       low_sw;
      logic       front_fog_on;
      logic       rear_fog_sw;
      logic       hazard_sw;
      logic [3:0] doors_closed;
      logic       remote_unlock;
      logic       remote_lock;
      logic       lock_secondary;
      logic       engine_running_status;
      logic       brake_pressed_status;
      logic [7:0] accelerator_position;
      logic [1:0] collision_output_status;
      logic [7:0] speed_kmh;
   } els_in_t;

   // Lamp drives and cluster status
   typedef struct packed {
      logic       low_beam;
      logic       high_beam;
      logic       position_lamp;
      logic       plate_lamp;
      logic       rear_fog;
      logic       drl;
      logic       hazard_lamp;
      logic       dipped_beam_status;
      logic       tail_lamp_status;
      logic       main_beam_status;
      logic       rear_fog_status;
      logic       hazard_ind;
      logic [8:0] follow_home_duration;
   } els_out_t;

endpackage

// ### els_sync.sv
/*
 * Two-stage synchroniser for a bundle of independent level inputs.
 * Assumes each bit is a slow level; multi-bit words must be stable
 * for several clocks around a change, as network values are.
 */
module els_sync #(
   parameter int W = 8
) (
   input  wire logic         core_clk,
   input  wire logic         srst,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);

   logic [W-1:0] meta_q;

   // First stage feeds only the second
   always_ff @(posedge core_clk) begin
      if (srst) begin
         meta_q <= '0;
         dout   <= '0;
      end else begin
         meta_q <= din;
         dout   <= meta_q;
      end
   end

endmodule

// ### els_top.sv
/*
 * Exterior lamp sequencer: follow-home and approach lighting, high
 * beam, passing flash, rear fog, daytime lamps and emergency-braking
 * hazard warning, with an APB register slave.
 * Assumes raw pins and network values are asynchronous levels, and
 * that lock/unlock commands are held long enough to be sampled.
 */
// The implementer's own choices: the APB interface to the registers and the register offsets.
// Notes on behaviour
// - Two-second flash hold cancels follow-home, zeroes status
// - Follow-home restartable inside two-minute key-off window
// - Follow-home stops on expiry, key on, switch off
// - Stop clears lamps, duration and status at once
// - Approach needs key off, cycle follow-home, unlock, doors
// - Approach ends on lock, door, key, 60 s
// - Approach lights low beam, position and plate
// - Approach timer runs 60 s from unlock
// - Follow-home start refused while approach lighting
// - Ignition cycle runs on, accessory, off
// - High beam needs key on, low beam, switch
// - High beam reports main beam status one
// - Passing flash needs key on and switch
// - Flash status one only with key on, or with key off in the window
// - Flash drives low and high beam together
// - Key-off window flash starts follow-home, status one
// - Rear fog toggles with switch, drops with load
// - Rear fog lamp reports rear fog status
// - Daytime lamps: key on, engine running, low beam switch off
// - Braking hazard flashes 200 ms for 3 s minimum
// - Deceleration from two five-sample speed averages
// - Accelerator, key off, hazard switch, collision stop warning
// - Follow-home 30 s, plus 30 s per press, eight max
module els_top
   import els_pkg::*;
#(
   parameter int TICK_CYCLES_P = TICK_CYCLES
) (
   input  wire logic        core_clk,
   input  wire logic        srst,
   input  wire els_in_t     lamp_in,
   output els_out_t         lamp_out,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr
);

   typedef enum logic {FH_OFF, FH_ON} els_fh_t;
   typedef enum logic {HZ_IDLE, HZ_RUN} els_hz_t;

   function automatic logic rise(input logic cur, input logic prev);
      return cur & ~prev;
   endfunction

   els_in_t         s;
   els_in_t         prev_q;
   logic [TICK_W-1:0] div_q;
   logic            tick_q;
   logic [1:0]      ctrl_q;
   logic [MS_W-1:0] win_q;
   els_fh_t         fh_q;
   els_fh_t         fh_d;
   logic [MS_W-1:0] fh_left_q;
   logic [3:0]      fh_ext_q;
   logic [11:0]     hold_q;
   logic            fh_cycle_q;
   logic            appr_q;
   logic [MS_W-1:0] appr_left_q;
   logic            rf_q;
   logic [3:0]      sdiv_q;
   logic [2:0]      nsamp_q;
   logic [10:0]     acc_q;
   logic [10:0]     sum_a_q;
   logic            have_a_q;
   logic            decel_hit_q;
   els_hz_t         hz_q;
   logic [11:0]     hz_min_q;
   logic [7:0]      hz_half_q;
   logic            hz_lamp_q;
   els_out_t        out_d;
   logic [31:0]     rd_mux;

   // Inputs pass two flip-flops before use
   els_sync #(.W($bits(els_in_t))) u_sync (
      .core_clk (core_clk),
      .srst     (srst),
      .din      (lamp_in),
      .dout     (s)
   );

   // Previous sample for edge detection
   always_ff @(posedge core_clk) begin
      if (srst) begin
         prev_q <= '0;
      end else begin
         prev_q <= s;
      end
   end

   // Millisecond tick for every timer
   always_ff @(posedge core_clk) begin
      if (srst) begin
         div_q  <= '0;
         tick_q <= 1'b0;
      end else if (div_q == TICK_W'(TICK_CYCLES_P - 1)) begin
         div_q  <= '0;
         tick_q <= 1'b1;
      end else begin
         div_q  <= div_q + 1'b1;
         tick_q <= 1'b0;
      end
   end

   // Decoded conditions
   wire key_off     = s.key_switch_position == KEY_OFF;
   wire key_on      = s.key_switch_position == KEY_ON;
   wire key_off_now = key_off & (prev_q.key_switch_position != KEY_OFF);
   wire flash_rise  = rise(s.flash_sw, prev_q.flash_sw);
   wire unlock_rise = rise(s.remote_unlock, prev_q.remote_unlock);
   wire lock_rise   = rise(s.remote_lock, prev_q.remote_lock);
   wire rf_rise     = rise(s.rear_fog_sw, prev_q.rear_fog_sw);
   wire haz_rise    = rise(s.hazard_sw, prev_q.hazard_sw);
   wire doors_shut  = &s.doors_closed;
   wire win_open    = win_q != '0;
   wire fh_en       = ctrl_q[CTRL_FH_EN];
   wire drl_en      = ctrl_q[CTRL_DRL_EN];

   // Two-minute window opened each time the key reaches off
   always_ff @(posedge core_clk) begin
      if (srst || !key_off) begin
         win_q <= '0;
      end else if (key_off_now) begin
         win_q <= KEYOFF_WIN_MS;
      end else if (tick_q && win_open) begin
         win_q <= win_q - 1'b1;
      end
   end

   // Follow-home start, extension and stop terms
   wire fh_start = (fh_q == FH_OFF) & key_off & win_open & fh_en
                   & ~appr_q & flash_rise;
   wire fh_long  = hold_q >= FLASH_LONG_MS;
   wire fh_stop  = (fh_left_q == '0) | ~key_off | ~fh_en
                   | fh_long;
   wire fh_ext   = flash_rise & (fh_ext_q < EXT_MAX);

   // Follow-home state
   always_comb begin
      case (fh_q)
         FH_OFF:  fh_d = fh_start ? FH_ON : FH_OFF;
         FH_ON:   fh_d = fh_stop ? FH_OFF : FH_ON;
         default: fh_d = FH_OFF;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         fh_q <= FH_OFF;
      end else begin
         fh_q <= fh_d;
      end
   end

   // Remaining time and extension count, zeroed on every stop
   always_ff @(posedge core_clk) begin
      if (srst || fh_d == FH_OFF) begin
         fh_left_q <= '0;
         fh_ext_q  <= '0;
      end else if (fh_q == FH_OFF) begin
         fh_left_q <= FH_STEP_MS;
         fh_ext_q  <= '0;
      end else if (fh_ext) begin
         fh_left_q <= fh_left_q + FH_STEP_MS;
         fh_ext_q  <= fh_ext_q + 1'b1;
      end else if (tick_q) begin
         fh_left_q <= fh_left_q - 1'b1;
      end
   end

   // Flash hold time, counted from each press while active
   always_ff @(posedge core_clk) begin
      if (srst || fh_q == FH_OFF || !s.flash_sw || flash_rise) begin
         hold_q <= '0;
      end else if (tick_q && !fh_long) begin
         hold_q <= hold_q + 1'b1;
      end
   end

   // Follow-home seen since the key was last on
   always_ff @(posedge core_clk) begin
      if (srst || key_on) begin
         fh_cycle_q <= 1'b0;
      end else if (fh_start) begin
         fh_cycle_q <= 1'b1;
      end
   end

   // Approach lighting start and stop terms
   wire appr_start = key_off & fh_cycle_q & unlock_rise
                     & doors_shut;
   wire appr_stop  = (lock_rise & ~s.lock_secondary) | ~doors_shut
                     | ~key_off | (appr_left_q == '0);

   always_ff @(posedge core_clk) begin
      if (srst) begin
         appr_q      <= 1'b0;
         appr_left_q <= '0;
      end else if (appr_start) begin
         appr_q      <= 1'b1;
         appr_left_q <= APPROACH_MS;
      end else if (appr_q && appr_stop) begin
         appr_q      <= 1'b0;
         appr_left_q <= '0;
      end else if (appr_q && tick_q) begin
         appr_left_q <= appr_left_q - 1'b1;
      end
   end

   // Beam requests
   wire fh_on    = fh_q == FH_ON;
   wire low_sw   = key_on & s.low_sw;
   wire high_on  = low_sw & s.high_sw;
   wire flash_on = key_on & s.flash_sw;
   wire low_on   = low_sw | fh_on | appr_q | flash_on;
   wire tail_on  = fh_on | appr_q;
   wire fog_load = s.front_fog_on | low_on;

   // Rear fog toggle, dropped with key or load
   always_ff @(posedge core_clk) begin
      if (srst || !key_on || !fog_load) begin
         rf_q <= 1'b0;
      end else if (rf_rise) begin
         rf_q <= ~rf_q;
      end
   end

   // Speed sampled every 10 ms into two five-sample sums
   wire sample = tick_q & (sdiv_q == SAMPLE_CNT - 1'b1);
   wire [10:0] sum_now = acc_q + {3'h0, s.speed_kmh};
   wire        sum_end = sample & (nsamp_q == SAMPLE_LAST);
   wire [14:0] diff_x10 = 15'((sum_a_q - sum_now) * 10);
   wire decel_test = have_a_q & (sum_a_q > SPEED_SUM_MIN)
                     & (sum_a_q > sum_now)
                     & (diff_x10 > DECEL_SUM_X10);

   always_ff @(posedge core_clk) begin
      if (srst || sample) begin
         sdiv_q <= '0;
      end else if (tick_q) begin
         sdiv_q <= sdiv_q + 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         nsamp_q     <= '0;
         acc_q       <= '0;
         sum_a_q     <= '0;
         have_a_q    <= 1'b0;
         decel_hit_q <= 1'b0;
      end else begin
         decel_hit_q <= sum_end & decel_test;
         if (sum_end) begin
            nsamp_q  <= '0;
            acc_q    <= '0;
            sum_a_q  <= sum_now;
            have_a_q <= 1'b1;
         end else if (sample) begin
            nsamp_q  <= nsamp_q + 1'b1;
            acc_q    <= sum_now;
         end
      end
   end

   // Emergency-braking hazard warning
   wire hz_trig  = decel_hit_q & key_on
                   & s.brake_pressed_status;
   wire hz_abort = (s.accelerator_position != '0) | key_off | haz_rise
                   | (s.collision_output_status != 2'h0);
   wire half_end = tick_q & (hz_half_q == 8'h01);

   always_ff @(posedge core_clk) begin
      if (srst) begin
         hz_q      <= HZ_IDLE;
         hz_min_q  <= '0;
         hz_half_q <= '0;
         hz_lamp_q <= 1'b0;
      end else begin
         case (hz_q)
            HZ_IDLE: begin
               if (hz_trig && !hz_abort) begin
                  hz_q      <= HZ_RUN;
                  hz_min_q  <= HAZ_MIN_MS;
                  hz_half_q <= HAZ_HALF_CNT;
                  hz_lamp_q <= 1'b1;
               end
            end
            HZ_RUN: begin
               if (hz_abort || (hz_min_q == '0 && !hz_trig)) begin
                  hz_q      <= HZ_IDLE;
                  hz_lamp_q <= 1'b0;
               end else begin
                  if (hz_trig) begin
                     hz_min_q <= HAZ_MIN_MS;
                  end else if (tick_q) begin
                     hz_min_q <= hz_min_q - 1'b1;
                  end
                  if (half_end) begin
                     hz_half_q <= HAZ_HALF_CNT;
                     hz_lamp_q <= ~hz_lamp_q;
                  end else if (tick_q) begin
                     hz_half_q <= hz_half_q - 1'b1;
                  end
               end
            end
            default: hz_q <= HZ_IDLE;
         endcase
      end
   end

   // Lamp drives and cluster status, registered below
   always_comb begin
      out_d = '0;
      out_d.low_beam      = low_on;
      out_d.high_beam     = high_on | flash_on;
      out_d.position_lamp = tail_on;
      out_d.plate_lamp    = tail_on;
      out_d.rear_fog      = rf_q;
      out_d.drl           = key_on & s.engine_running_status & drl_en
                            & ~high_on & ~low_sw;
      out_d.hazard_lamp   = hz_lamp_q;
      out_d.hazard_ind    = hz_lamp_q;
      out_d.dipped_beam_status = low_on;
      out_d.tail_lamp_status   = tail_on;
      out_d.main_beam_status   = high_on | flash_on
                                 | (key_off & win_open & fh_en
                                 & s.flash_sw);
      out_d.rear_fog_status    = rf_q;
      out_d.follow_home_duration = fh_on ?
         9'(FH_STEP_S * (32'(fh_ext_q) + 1)) : 9'h000;
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         lamp_out <= '0;
      end else begin
         lamp_out <= out_d;
      end
   end

   // APB decode; answer prepared in setup, given in first access cycle
   wire setup    = psel & ~penable;
   wire access   = psel & penable & pready;
   wire sel_ctrl = paddr == REG_CTRL;
   wire sel_stat = paddr == REG_STATUS;
   wire sel_dur  = paddr == REG_DURATION;
   wire mapped   = sel_ctrl | sel_stat | sel_dur;

   assign rd_mux = sel_ctrl ? {30'h0000_0000, ctrl_q} :
                   sel_stat ? {22'h00_0000, fh_cycle_q, hz_q == HZ_RUN,
                               appr_q, fh_q == FH_ON, lamp_out[20:15]} :
                   sel_dur  ? {23'h00_0000,
                               lamp_out.follow_home_duration} :
                   32'h0000_0000;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else begin
         pready  <= setup;
         pslverr <= setup & ~mapped;
         prdata  <= (setup & ~pwrite) ? rd_mux : 32'h0000_0000;
      end
   end

   // Control register, written at the completing edge
   always_ff @(posedge core_clk) begin
      if (srst) begin
         ctrl_q <= CTRL_RESET;
      end else if (access && pwrite && sel_ctrl) begin
         ctrl_q <= pwdata[1:0];
      end
   end

endmodule

// ### els_asserts.sv
/*
 * Checker for the exterior lamp sequencer outputs.
 * Assumes it is bound to els_top and sees only its lamp ports.
 */
module els_asserts
   import els_pkg::*;
#(
   parameter int TICK_CYCLES_P = 1
) (
   input wire logic     core_clk,
   input wire logic     srst,
   input wire els_in_t  lamp_in,
   input wire els_out_t lamp_out
);
   // All checks sample on the core clock and rest during reset
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);

   // Shared beam load and cluster status bits
   AST_HIGH_LOAD: assert property (lamp_out.high_beam |-> lamp_out.low_beam)
      else $error("high beam lit without low beam");
   AST_HIGH_STS: assert property (lamp_out.high_beam |-> lamp_out.main_beam_status)
      else $error("high beam status missing");
   AST_FOG_STS: assert property (lamp_out.rear_fog |-> lamp_out.rear_fog_status)
      else $error("rear fog status missing");

   // Key away from on drops the switched lamps after the sync delay
   AST_KEY_OFF: assert property ((lamp_in.key_switch_position != KEY_ON)[*5]
      |-> !lamp_out.drl && !lamp_out.high_beam && !lamp_out.rear_fog)
      else $error("lamp lit with key not on");
   AST_FLASH_ACC: assert property ((lamp_in.key_switch_position == KEY_ACC)[*5]
      |-> !lamp_out.main_beam_status)
      else $error("high beam status in accessory");
   AST_HB_SW: assert property ((!lamp_in.high_sw && !lamp_in.flash_sw)[*5]
      |-> !lamp_out.high_beam)
      else $error("high beam without its switches");

   // Follow-home duration steps and the lamps it keeps lit
   AST_FH_LAMPS: assert property (lamp_out.follow_home_duration != 9'h000
      |-> lamp_out.low_beam && lamp_out.position_lamp && lamp_out.plate_lamp
          && lamp_out.dipped_beam_status && lamp_out.tail_lamp_status)
      else $error("follow-home without its lamps");
   AST_FH_STEP: assert property (lamp_out.follow_home_duration % 9'h01E == 9'h000
      && lamp_out.follow_home_duration <= 9'h10E)
      else $error("follow-home duration off step");
   AST_FH_KEY: assert property ((lamp_in.key_switch_position != KEY_OFF)[*5]
      |-> lamp_out.follow_home_duration == 9'h000)
      else $error("follow-home kept with key not off");

   // Braking warning aborts at once
   AST_ABORT: assert property ((lamp_in.accelerator_position != 8'h00
      || lamp_in.collision_output_status != 2'h0
      || lamp_in.key_switch_position == KEY_OFF)[*5]
      |-> !lamp_out.hazard_lamp && !lamp_out.hazard_ind)
      else $error("braking warning not aborted");
endmodule

bind els_top els_asserts #(.TICK_CYCLES_P(TICK_CYCLES_P)) i_chk (
   .core_clk (core_clk),
   .srst     (srst),
   .lamp_in  (lamp_in),
   .lamp_out (lamp_out)
);

// ### els_net_model.sv
/*
 * Network partner: engine controller speed and running status.
 * Assumes callers enter drive() just after a rising clock edge.
 */
module els_net_model #(
   parameter int TICK_CYCLES_P = 1
) (
   input  wire logic       core_clk,
   output logic      [7:0] speed_kmh,
   output logic            engine_running_status
);
   timeunit 1ns;
   timeprecision 1ps;

   // Engine reports running, vehicle standing
   initial begin
      speed_kmh = 8'h00;
      engine_running_status = 1'b1;
   end

   // Hold one speed for the given milliseconds of message slots
   task automatic drive(input logic [7:0] v, input int ms);
      speed_kmh <= v;
      repeat (ms * TICK_CYCLES_P) @(posedge core_clk);
   endtask
endmodule

// ### els_top_tb.sv
/*
 * Self-checking bench for els_top: lamp scenarios and APB access.
 * Assumes a one-cycle millisecond tick so timers stay short.
 */
module els_top_tb
   import els_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int TICK  = 1;
   localparam int LIMIT = 90000;

   logic        core_clk;
   logic        srst;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic        pready;
   logic        pslverr;
   logic        err;
   logic [31:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic [7:0]  spd;
   logic        eng;
   els_in_t     drv;
   els_in_t     lin;
   els_out_t    lout;
   int          err_count;
   int          n_checks;
   int          cyc;
   int          k;

   // Switch inputs from the bench, engine values from the partner
   always_comb begin
      lin = drv;
      lin.speed_kmh = spd;
      lin.engine_running_status = eng;
   end

   els_top #(.TICK_CYCLES_P(TICK)) i_dut (
      .core_clk (core_clk), .srst (srst), .lamp_in (lin),
      .lamp_out (lout), .psel (psel), .penable (penable),
      .pwrite (pwrite), .paddr (paddr), .pwdata (pwdata),
      .prdata (prdata), .pready (pready), .pslverr (pslverr));
   els_net_model #(.TICK_CYCLES_P(TICK)) i_net (
      .core_clk (core_clk), .speed_kmh (spd),
      .engine_running_status (eng));

   // 250 MHz clock
   initial core_clk = 1'b0;
   always #2 core_clk = ~core_clk;

   // Hang guard
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         err_count++;
         stop_test();
      end
   end

   task automatic stop_test();
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   // One APB transfer; waits for pready, the hang guard bounds the wait
   task automatic apb(input logic w, input logic [31:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask

   // Lamps that follow-home keeps lit, with their status bits
   function automatic logic [4:0] lit();
      return {lout.low_beam, lout.position_lamp, lout.plate_lamp,
              lout.dipped_beam_status, lout.tail_lamp_status};
   endfunction

   task automatic fog();
      drv.rear_fog_sw <= 1'b1;
      wt(8);
      drv.rear_fog_sw <= 1'b0;
      wt(8);
   endtask

   task automatic flash(input logic v);
      drv.flash_sw <= v;
      wt(8);
   endtask

   task automatic unlock();
      drv.remote_unlock <= 1'b1;
      wt(8);
      drv.remote_unlock <= 1'b0;
      wt(4);
   endtask

   // Main sequence
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      drv = '0;
      srst = 1'b1;
      err_count = 0;
      n_checks = 0;
      cyc = 0;
      wt(2);
      srst <= 1'b0;
      wt(4);
      chk(lout, 64'h0);
      apb(1'b0, REG_CTRL, 32'h0);
      chk(rd, 64'h3);
      apb(1'b0, 32'h0000_0010, 32'h0);
      chk({err, rd}, 64'h0000_0001_0000_0000);
      // Key on: daytime lamps, beams, rear fog
      drv.key_switch_position <= KEY_ON;
      drv.doors_closed <= 4'hF;
      wt(8);
      chk(lout.drl, 1'h1);
      drv.low_sw <= 1'b1;
      drv.high_sw <= 1'b1;
      wt(8);
      chk({lout.low_beam, lout.high_beam, lout.main_beam_status, lout.drl}, 4'hE);
      fog();
      chk({lout.rear_fog, lout.rear_fog_status}, 2'h3);
      fog();
      chk(lout.rear_fog, 1'h0);
      fog();
      drv.low_sw <= 1'b0;
      drv.high_sw <= 1'b0;
      wt(8);
      chk({lout.rear_fog, lout.high_beam, lout.drl}, 3'h1);
      flash(1'b1);
      chk({lout.low_beam, lout.high_beam, lout.main_beam_status, lout.drl}, 4'hF);
      drv.key_switch_position <= KEY_ACC;
      flash(1'b0);
      flash(1'b1);
      chk({lout.high_beam, lout.main_beam_status}, 2'h0);
      drv.key_switch_position <= KEY_OFF;
      flash(1'b0);
      // Follow-home in the key-off window
      flash(1'b1);
      chk({lit(), lout.main_beam_status, lout.high_beam}, 7'h7E);
      chk(lout.follow_home_duration, 9'h01E);
      flash(1'b0);
      flash(1'b1);
      flash(1'b0);
      chk(lout.follow_home_duration, 9'h03C);
      flash(1'b1);
      wt(1980 * TICK);
      chk(lit(), 5'h1F);
      wt(20 * TICK);
      chk({lit(), lout.follow_home_duration}, 14'h0);
      flash(1'b0);
      flash(1'b1);
      chk(lout.follow_home_duration, 9'h01E);
      flash(1'b0);
      apb(1'b1, REG_CTRL, 32'h0000_0002);
      wt(6);
      chk({lit(), lout.follow_home_duration}, 14'h0);
      apb(1'b1, REG_CTRL, 32'h0000_0003);
      flash(1'b1);
      flash(1'b0);
      drv.key_switch_position <= KEY_ACC;
      wt(8);
      chk({lit(), lout.follow_home_duration}, 14'h0);
      drv.key_switch_position <= KEY_OFF;
      // Approach lighting
      drv.doors_closed <= 4'h7;
      unlock();
      chk(lit(), 5'h00);
      drv.doors_closed <= 4'hF;
      unlock();
      chk(lit() >> 2, 3'h7);
      flash(1'b1);
      flash(1'b0);
      chk(lout.follow_home_duration, 9'h000);
      drv.doors_closed <= 4'hE;
      wt(8);
      chk(lit() >> 2, 3'h0);
      drv.doors_closed <= 4'hF;
      unlock();
      drv.lock_secondary <= 1'b1;
      drv.remote_lock <= 1'b1;
      wt(8);
      chk(lit() >> 2, 3'h7);
      drv.remote_lock <= 1'b0;
      drv.lock_secondary <= 1'b0;
      wt(8);
      drv.remote_lock <= 1'b1;
      wt(8);
      chk(lit() >> 2, 3'h0);
      drv.remote_lock <= 1'b0;
      unlock();
      wt(59970 * TICK);
      chk(lit() >> 2, 3'h7);
      wt(30 * TICK);
      chk(lit() >> 2, 3'h0);
      // Emergency braking warning
      drv.key_switch_position <= KEY_ON;
      drv.brake_pressed_status <= 1'b1;
      i_net.drive(8'h64, 120);
      i_net.drive(8'h28, 0);
      k = 0;
      while (lout.hazard_lamp !== 1'b1 && k < 400) begin
         wt(1);
         k++;
      end
      wt(100 * TICK);
      chk(lout.hazard_lamp, 1'h1);
      wt(200 * TICK);
      chk(lout.hazard_lamp, 1'h0);
      wt(150 * TICK);
      chk({lout.hazard_lamp, lout.hazard_ind}, 2'h3);
      drv.accelerator_position <= 8'h01;
      wt(8);
      chk({lout.hazard_lamp, lout.hazard_ind}, 2'h0);
      stop_test();
   end
endmodule
